// ---- bench/mdc_core_model.sv ----
// mdc_core_model: stands in for the core issuing coprocessor ops
// assumes the unit answers with done_i and stalls with busy_i
module mdc_core_model
(
	input wire logic mclk_i, // core clock
	input wire logic busy_i, // unit stall request
	input wire logic done_i, // answer valid pulse
	output logic mode_wr_o, // mode write strobe
	output logic [6:0] mode_o, // mode word
	output logic comp_o, // compute strobe
	output logic load_o, // preset load strobe
	output logic [15:0] opa_o, // destination operand
	output logic [15:0] opb_o // source operand
);
	timeunit 1ns;
	timeprecision 1ps;
	int lat;
	int hangs;
	logic busy_take;
	// idle bus at time zero
	initial
	begin
		mode_wr_o = 1'b0;
		comp_o = 1'b0;
		load_o = 1'b0;
		mode_o = 7'h00;
		opa_o = 16'h0000;
		opb_o = 16'h0000;
		hangs = 0;
		busy_take = 1'b0;
	end
	// kind 0 mode write, 1 preset load, 2 compute; lat counts to done
	task automatic send(input int kind, input logic [6:0] m,
		input logic [15:0] a, input logic [15:0] b);
		@(negedge mclk_i);
		for (int i = 0; i < 40 && busy_i === 1'b1; i++)
			@(negedge mclk_i);
		// a stall that never ends is counted, the bench stops on it
		if (busy_i === 1'b1)
			hangs++;
		// mode word sent with its strobe
		mode_o = m;
		opa_o = a;
		opb_o = b;
		mode_wr_o = (kind == 0);
		load_o = (kind == 1);
		comp_o = (kind == 2);
		@(negedge mclk_i);
		mode_wr_o = 1'b0;
		load_o = 1'b0;
		comp_o = 1'b0;
		busy_take = busy_i;
		lat = 0;
		// bounded wait, so a silent unit cannot hang the run
		while (kind == 2 && done_i !== 1'b1 && lat < 40)
		begin
			@(negedge mclk_i);
			lat++;
		end
		if (kind == 2 && done_i !== 1'b1)
			hangs++;
	endtask
endmodule

// ---- bench/tb_mdc_coproc.sv ----
// tb_mdc_coproc: directed checks of the arithmetic coprocessor
// assumes the core model drives all strobes on falling edges
module tb_mdc_coproc;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i, rstn_i, mw, comp, load, done, busy;
	logic [6:0] mode;
	logic [15:0] opa, opb, res;
	logic [3:0] flg, opm;
	int errors, cmp_count;
	mdc_core_model core_u (.mclk_i(mclk_i), .busy_i(busy), .done_i(done),
		.mode_wr_o(mw), .mode_o(mode), .comp_o(comp), .load_o(load),
		.opa_o(opa), .opb_o(opb));
	mdc_coproc dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i),
		.mode_write_op_i(mw), .mode_i(mode), .compute_op_i(comp),
		.preset_load_op_i(load), .opa_i(opa), .opb_i(opb),
		.result_o(res), .flags_o(flg), .done_o(done), .busy_o(busy),
		.op_mode_o(opm));
	// 250 MHz core clock
	initial
	begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk_res(input string n, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_flg(input string n, input logic [3:0] e,
		input logic [3:0] g);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// answer must launch within the given span of edges after the take
	task automatic chk_lat(input int lo, input int hi);
		cmp_count++;
		if (core_u.lat < lo || core_u.lat > hi)
		begin
			errors++;
			$display("mismatch latency expected %0d..%0d seen %0d", lo, hi,
				core_u.lat);
		end
	endtask
	task automatic chk_bit(input string n, input logic e, input logic g);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %b seen %b", n, e, g);
		end
	endtask
	// compute in the current mode, then compare half and flags
	task automatic cmp_op(input logic [6:0] m, input logic [15:0] a,
		input logic [15:0] b, input logic [15:0] er, input logic [3:0] ef);
		core_u.send(2, m, a, b);
		if (core_u.hangs != 0)
		begin
			errors++;
			conclude();
		end
		chk_res("result", er, res);
		chk_flg("flags", ef, flg);
	endtask
	task automatic run(input logic [6:0] m, input logic [15:0] a,
		input logic [15:0] b, input logic [15:0] er, input logic [3:0] ef);
		core_u.send(0, m, 16'h0000, 16'h0000);
		cmp_op(m, a, b, er, ef);
	endtask
	initial
	begin
		errors = 0;
		cmp_count = 0;
		rstn_i = 1'b0;
		repeat (5) @(negedge mclk_i);
		rstn_i = 1'b1;
		chk_res("reset result", 16'h0000, res);
		run(7'h04, 16'hFFFF, 16'hFFFF, 16'h0001, 4'h0);
		chk_lat(0, 0);
		chk_bit("busy on multiply", 1'b0, core_u.busy_take);
		chk_flg("op mode", 4'h4, opm);
		run(7'h13, 16'h0000, 16'h0000, 16'hFFFE, 4'h0);
		run(7'h15, 16'hFFFF, 16'h0002, 16'hFFFF, 4'h0);
		run(7'h03, 16'h0000, 16'h0000, 16'hFFFE, 4'h0);
		run(7'h15, 16'h0100, 16'h0100, 16'h0001, 4'h0);
		$display("test multiply finished");
		run(7'h08, 16'h0064, 16'h0007, 16'h000E, 4'h0);
		chk_lat(17, 20);
		chk_bit("busy at take", 1'b1, core_u.busy_take);
		chk_bit("busy at answer", 1'b0, busy);
		run(7'h13, 16'h0000, 16'h0000, 16'h0002, 4'h0);
		run(7'h19, 16'hFFF9, 16'h0002, 16'hFFFF, 4'h0);
		chk_lat(17, 20);
		run(7'h03, 16'h0000, 16'h0000, 16'hFFFD, 4'h0);
		run(7'h08, 16'hFFFF, 16'h8001, 16'h0001, 4'h0);
		run(7'h13, 16'h0000, 16'h0000, 16'h7FFE, 4'h0);
		$display("test divide finished");
		core_u.send(0, 7'h00, 16'h0000, 16'h0000);
		run(7'h13, 16'h0000, 16'h0000, 16'h0000, 4'h0);
		core_u.send(0, 7'h01, 16'h0000, 16'h0000);
		core_u.send(1, 7'h01, 16'h1234, 16'h5678);
		run(7'h13, 16'h0000, 16'h0000, 16'h0000, 4'h0);
		run(7'h03, 16'h0000, 16'h0000, 16'h5678, 4'h0);
		core_u.send(0, 7'h02, 16'h0000, 16'h0000);
		core_u.send(1, 7'h02, 16'h7FFF, 16'hFFFF);
		run(7'h13, 16'h0000, 16'h0000, 16'h7FFF, 4'h0);
		$display("test preset finished");
		run(7'h07, 16'h0001, 16'h0001, 16'h0000, 4'h4);
		cmp_op(7'h07, 16'h0000, 16'h0000, 16'h0000, 4'h0);
		run(7'h17, 16'hFFFF, 16'h0001, 16'h7FFF, 4'h4);
		run(7'h06, 16'h1111, 16'h2222, 16'hFFFF, 4'h0);
		run(7'h13, 16'h0000, 16'h0000, 16'h7FFF, 4'h0);
		$display("test accumulate finished");
		// second reset in mid-run, asserted on a falling edge
		rstn_i = 1'b0;
		repeat (2) @(negedge mclk_i);
		rstn_i = 1'b1;
		chk_flg("op mode after reset", 4'h0, opm);
		chk_res("result after reset", 16'h0000, res);
		run(7'h13, 16'h0000, 16'h0000, 16'h0000, 4'h0);
		$display("test reset finished");
		conclude();
	end
endmodule

// ---- common/mdc_pkg.sv ----
// mdc_pkg: constants for the multiply/divide/accumulate coprocessor
// assumes a 16-bit core issuing one coprocessor operation at a time
package mdc_pkg;
	localparam int DATA_W = 16;
	localparam int RES_W = 32;
	localparam int MODE_W = 7;
	localparam int OPM_W = 4;
	localparam int OUTM_W = 3;
	localparam int OPM_LSB = 0;
	localparam int OUTM_LSB = 4;
	localparam int FLAG_W = 4;
	// output half selector values
	localparam logic [2:0] OUT_LOW = 3'h0;
	localparam logic [2:0] OUT_HIGH = 3'h1;
	// operation mode codes
	localparam logic [3:0] OPM_CLEAR = 4'h0;
	localparam logic [3:0] OPM_LOAD16 = 4'h1;
	localparam logic [3:0] OPM_LOAD32 = 4'h2;
	localparam logic [3:0] OPM_READ = 4'h3;
	localparam logic [3:0] OPM_MULU = 4'h4;
	localparam logic [3:0] OPM_MULS = 4'h5;
	localparam logic [3:0] OPM_MAC = 4'h7;
	localparam logic [3:0] OPM_DIVU = 4'h8;
	localparam logic [3:0] OPM_DIVS = 4'h9;
	// flag patterns, carry/overflow/zero/negative from bit 3 down
	localparam logic [3:0] FLAGS_NONE = 4'h0;
	localparam logic [3:0] FLAGS_OVF = 4'h4;
	// reset values
	localparam logic [6:0] MODE_RESET = 7'h00;
	localparam logic [31:0] RES_RESET = 32'h0000_0000;
	// divider timing: one setup cycle, 16 steps, one fix-up cycle
	localparam int DIV_STEPS = 16;
	localparam logic [4:0] DIV_CNT_W5 = 5'h10;
endpackage

// ---- core/mdc_coproc.sv ----
// mdc_coproc: multiply, signed accumulate and divide coprocessor
// assumes the core holds operands steady and waits while busy_o is high
module mdc_coproc
(
	input wire logic mclk_i, // core clock, 250 MHz
	input wire logic rstn_i, // synchronous reset, active low
	input wire logic mode_write_op_i, // mode word write strobe
	input wire logic [6:0] mode_i, // mode word, half and op mode
	input wire logic compute_op_i, // compute strobe
	input wire logic preset_load_op_i, // preset load strobe
	input wire logic [15:0] opa_i, // destination operand
	input wire logic [15:0] opb_i, // source operand
	output logic [15:0] result_o, // returned result half
	output logic [3:0] flags_o, // carry_ovf_zero_neg_flags
	output logic done_o, // result_o valid, one cycle
	output logic busy_o, // divider running, core must stall
	output logic [3:0] op_mode_o // latched op mode, for status
);
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_DIV = 2'b01,
		ST_FIX = 2'b10
	} mdc_state_type;

	typedef struct packed
	{
		mdc_state_type st;
		logic [2:0] out_sel;
		logic [3:0] op_mode;
		logic [31:0] res;
		logic ovf;
		logic [15:0] rem;
		logic [15:0] quo;
		logic [15:0] dvs;
		logic [4:0] cnt;
		logic neg_q;
		logic neg_r;
		logic [15:0] out;
		logic [3:0] flags;
		logic done;
		logic busy;
	} mdc_regs_type;

	mdc_regs_type r;
	mdc_regs_type next_r;

	// pick one half of the result by the output selector
	// low or high half
	function automatic logic [15:0] mdc_half(input logic [31:0] v,
		input logic [2:0] sel);
		logic [15:0] h;
		h = v[15:0];
		if (sel == mdc_pkg::OUT_HIGH)
			h = v[31:16];
		return h;
	endfunction

	// two's complement magnitude of a 16-bit value
	function automatic logic [15:0] mdc_abs(input logic [15:0] v,
		input logic sgn);
		logic [15:0] m;
		m = v;
		if (sgn && v[15])
			m = 16'(~v + 16'h0001);
		return m;
	endfunction

	logic [31:0] prod_u;
	logic [31:0] prod_s;
	logic [31:0] mac_sum;
	logic mac_ovf;
	logic [16:0] trial;
	logic [15:0] shifted_rem;
	logic div_signed;

	// combinational arithmetic for the single-cycle modes and the divider step
	always_comb
	begin
		// widen before multiplying: a size cast alone keeps 16 bits
		prod_u = 32'({16'h0000, opa_i} * {16'h0000, opb_i});
		prod_s = 32'({{mdc_pkg::DATA_W{opa_i[15]}}, opa_i}
			* {{mdc_pkg::DATA_W{opb_i[15]}}, opb_i});
		mac_sum = 32'(prod_s + r.res);
		mac_ovf = (prod_s[31] == r.res[31]) && (mac_sum[31] != prod_s[31]);
		shifted_rem = {r.rem[14:0], r.quo[15]};
		trial = {1'b0, shifted_rem} - {1'b0, r.dvs};
		div_signed = (r.op_mode == mdc_pkg::OPM_DIVS);
	end

	// next state: mode writes, presets, single-cycle ops and divider
	always_comb
	begin
		// result holds unless an operation writes it
		next_r = r;
		next_r.done = 1'b0;
		unique case (r.st)
			ST_IDLE:
			begin
				if (mode_write_op_i)
				begin
					next_r.out_sel = mode_i[6:4];
					next_r.op_mode = mode_i[3:0];
					if (mode_i[3:0] == mdc_pkg::OPM_CLEAR)
						next_r.res = mdc_pkg::RES_RESET;
				end
				else if (preset_load_op_i)
				begin
					next_r.ovf = 1'b0;
					if (r.op_mode == mdc_pkg::OPM_LOAD16)
						next_r.res = {16'h0000, opb_i};
					else if (r.op_mode == mdc_pkg::OPM_LOAD32)
						next_r.res = {opa_i, opb_i};
				end
				else if (compute_op_i)
				begin
					// every answer starts with all flags clear
					next_r.flags = mdc_pkg::FLAGS_NONE;
					next_r.done = 1'b1;
					if (r.op_mode != mdc_pkg::OPM_READ)
						next_r.ovf = 1'b0;
					next_r.out = mdc_half(r.res, r.out_sel);
					// multiply and mac settle in one cycle
					unique case (r.op_mode)
						mdc_pkg::OPM_MULU:
						begin
							next_r.res = prod_u;
							next_r.out = mdc_half(prod_u, r.out_sel);
						end
						mdc_pkg::OPM_MULS:
						begin
							next_r.res = prod_s;
							next_r.out = mdc_half(prod_s, r.out_sel);
						end
						mdc_pkg::OPM_MAC:
						begin
							next_r.res = mac_sum;
							next_r.out = mdc_half(mac_sum, r.out_sel);
							next_r.ovf = mac_ovf;
							if (mac_ovf)
								next_r.flags = mdc_pkg::FLAGS_OVF;
						end
						// start the divider, stall the core
						mdc_pkg::OPM_DIVU, mdc_pkg::OPM_DIVS:
						begin
							next_r.done = 1'b0;
							next_r.busy = 1'b1;
							next_r.st = ST_DIV;
							next_r.rem = 16'h0000;
							next_r.quo = mdc_abs(opa_i, div_signed);
							next_r.dvs = mdc_abs(opb_i, div_signed);
							next_r.neg_q = div_signed && (opa_i[15] ^ opb_i[15]);
							next_r.neg_r = div_signed && opa_i[15];
							next_r.cnt = mdc_pkg::DIV_CNT_W5;
						end
						default:
						begin
							next_r.res = r.res;
						end
					endcase
				end
			end
			// one restoring step per cycle, sixteen steps
			ST_DIV:
			begin
				if (!trial[16])
				begin
					next_r.rem = trial[15:0];
					next_r.quo = {r.quo[14:0], 1'b1};
				end
				else
				begin
					next_r.rem = shifted_rem;
					next_r.quo = {r.quo[14:0], 1'b0};
				end
				next_r.cnt = 5'(r.cnt - 5'h01);
				if (r.cnt == 5'h01)
					next_r.st = ST_FIX;
			end
			// sign fix-up, store and return; busy drops with done
			ST_FIX:
			begin
				next_r.res[15:0] = r.neg_q ? 16'(~r.quo + 16'h0001) : r.quo;
				next_r.res[31:16] = r.neg_r ? 16'(~r.rem + 16'h0001) : r.rem;
				next_r.out = mdc_half(next_r.res, r.out_sel);
				next_r.flags = mdc_pkg::FLAGS_NONE;
				next_r.done = 1'b1;
				next_r.busy = 1'b0;
				next_r.st = ST_IDLE;
			end
			default:
			begin
				next_r.st = ST_IDLE;
				next_r.busy = 1'b0;
			end
		endcase
	end

	// single register bank; reset gives defined control state
	always_ff @(posedge mclk_i)
	begin
		if (!rstn_i)
		begin
			r <= '0;
			r.st <= ST_IDLE;
			r.out_sel <= mdc_pkg::MODE_RESET[6:4];
			r.op_mode <= mdc_pkg::MODE_RESET[3:0];
			r.res <= mdc_pkg::RES_RESET;
		end
		else
			r <= next_r;
	end

	// outputs straight from flip-flops
	assign result_o = r.out;
	assign flags_o = r.flags;
	assign done_o = r.done;
	assign busy_o = r.busy;
	assign op_mode_o = r.op_mode;

	// carry, zero and negative never set
	// zero/neg/carry lanes are zero in every flags value
	chk_flags_cznz: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(flags_o & 4'hB) == 4'h0)
		else $error("carry/zero/negative flag set");

	chk_clear_mode: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		mode_write_op_i && !busy_o && mode_i[3:0] == 4'h0 |=> r.res == 32'h0)
		else $error("clear mode did not zero result");

	chk_preset_low: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		preset_load_op_i && !mode_write_op_i && !busy_o && r.op_mode == 4'h1
		|=> r.res == {16'h0, $past(opb_i)})
		else $error("16-bit preset wrong");

	chk_preset_full: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		preset_load_op_i && !mode_write_op_i && !busy_o && r.op_mode == 4'h2
		|=> r.res == {$past(opa_i), $past(opb_i)})
		else $error("32-bit preset wrong");

	chk_read_keep: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		compute_op_i && !mode_write_op_i && !preset_load_op_i && !busy_o
		&& r.op_mode == 4'h3 |=> $stable(r.res) && done_o)
		else $error("read mode changed result");

	chk_mul_unsigned: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		compute_op_i && !mode_write_op_i && !preset_load_op_i && !busy_o
		&& r.op_mode == mdc_pkg::OPM_MULU
		|=> r.res == 32'({16'h0000, $past(opa_i)} * {16'h0000, $past(opb_i)})
		&& done_o)
		else $error("unsigned product wrong or late");

	sequence mdc_mac_issue;
		compute_op_i && !mode_write_op_i && !preset_load_op_i && !busy_o
		&& r.op_mode == 4'h7;
	endsequence
	chk_mac_ovf: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		mdc_mac_issue |=> flags_o == ($past(mac_ovf) ? 4'h4 : 4'h0))
		else $error("mac overflow flag wrong");

	// internal overflow state matches the returned flag
	chk_ovf_track: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		mdc_mac_issue |=> r.ovf == (flags_o == mdc_pkg::FLAGS_OVF))
		else $error("overflow state and flag disagree");

	sequence mdc_div_issue;
		compute_op_i && !mode_write_op_i && !preset_load_op_i && !busy_o
		&& (r.op_mode == 4'h8 || r.op_mode == 4'h9);
	endsequence
	chk_div_time: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		mdc_div_issue |=> busy_o [*8] ##[9:12] (done_o && !busy_o))
		else $error("division latency out of range");

	chk_half_select: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		compute_op_i && !mode_write_op_i && !preset_load_op_i && !busy_o
		&& r.op_mode == 4'h3 && r.out_sel == 3'h1
		|=> result_o == $past(r.res[31:16]))
		else $error("high half not returned");

	// signed product, both operands sign-extended first
	chk_mul_signed: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		compute_op_i && !mode_write_op_i && !preset_load_op_i && !busy_o
		&& r.op_mode == mdc_pkg::OPM_MULS
		|=> r.res == 32'({{16{$past(opa_i[15])}}, $past(opa_i)}
		* {{16{$past(opb_i[15])}}, $past(opb_i)}))
		else $error("signed product wrong");

	// overflow state dropped by preset or by a compute outside read and mac modes
	chk_ovf_clear: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!mode_write_op_i && !busy_o && (preset_load_op_i || (compute_op_i
		&& r.op_mode != mdc_pkg::OPM_READ && r.op_mode != mdc_pkg::OPM_MAC))
		|=> !r.ovf)
		else $error("overflow state not cleared");

	// partial remainder stays below a nonzero divisor
	chk_rem_range: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		r.st == ST_DIV && r.dvs != 16'h0000 |-> r.rem < r.dvs)
		else $error("partial remainder out of range");

	// the stall ends exactly when the answer is shown
	chk_busy_fall: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		$fell(busy_o) |-> done_o)
		else $error("busy dropped without an answer");
endmodule
